// ===== shared/pmio_pkg.sv
/*
 * Constants and types of the macrocell and I/O port block.
 * Assumes a synchronous MCU register bus sampled on core_clk.
 */
package pmio_pkg;

    // ****************************************
    // Register offsets within the I/O space
    // ****************************************
    localparam logic [7:0] OFS_DIN     = 8'h00; // Plus port index 0..3
    localparam logic [7:0] OFS_DOUT    = 8'h04;
    localparam logic [7:0] OFS_DIR     = 8'h08;
    localparam logic [7:0] OFS_CTL_A   = 8'h0c;
    localparam logic [7:0] OFS_CTL_B   = 8'h0d;
    localparam logic [7:0] OFS_MC_AB   = 8'h0e;
    localparam logic [7:0] OFS_MC_BC   = 8'h0f;
    localparam logic [7:0] OFS_MASK_AB = 8'h10;
    localparam logic [7:0] OFS_MASK_BC = 8'h11;
    localparam logic [7:0] OFS_IMC_A   = 8'h12;
    localparam logic [7:0] OFS_IMC_B   = 8'h13;
    localparam logic [7:0] OFS_IMC_C   = 8'h14;

    // ****************************************
    // Reset values and field layouts
    // ****************************************
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [7:0] RST_DIR  = 8'h00;
    localparam logic [7:0] RST_CTL  = 8'h00;
    localparam logic [7:0] RST_DOUT = 8'h00;
    localparam int PORT_W   = 8;
    localparam int PORT_D_W = 3;
    localparam int GRP_W    = 4;  // Input cells per control term
    localparam int ECS_POS  = 1;  // Chip selects on port D bits 2..1
    localparam logic [7:0] PC_CELL_PINS = 8'h9c; // Pins 7,4,3,2

    // Product-term budget, for reference by configuration tools
    localparam int PT_AB_NATIVE = 3;
    localparam int PT_AB_BORROW = 6;
    localparam int PT_BC_NATIVE = 4;
    localparam int PT_BC_LO_BOR = 5;
    localparam int PT_BC_HI_BOR = 6;

    typedef enum logic [1:0] {
        IMC_PASS  = 2'b00,
        IMC_LATCH = 2'b01,
        IMC_REG   = 2'b11
    } pmio_imc_mode_type;

endpackage : pmio_pkg

// ===== hw/pmio_output_cell.sv
/*
 * Group of output macrocell flip-flops with MCU load override.
 * Assumes load_en is a one-cycle pulse already gated by the mask.
 */
`timescale 1ns/10ps
module pmio_output_cell
    import pmio_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         core_clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] load_en,
    input  wire logic [W-1:0] load_data,
    input  wire logic [W-1:0] pt_d,
    input  wire logic [W-1:0] pt_clk,
    input  wire logic [W-1:0] pt_pre,
    input  wire logic [W-1:0] pt_clr,
    input  wire logic [W-1:0] cfg_comb,
    output logic      [W-1:0] cell_q,
    output logic      [W-1:0] cell_out
);
    typedef struct packed {
        logic [W-1:0] ff;
        logic [W-1:0] clk_prev;
    } pmio_oc_state_type;

    pmio_oc_state_type st_q, st_d;

    always_comb begin
        st_d          = st_q;
        st_d.clk_prev = pt_clk;
        for (int i = 0; i < W; i++) begin
            // MCU load wins over preset, clear and clock
            if (load_en[i]) begin
                st_d.ff[i] = load_data[i];
            end else if (pt_pre[i]) begin
                st_d.ff[i] = 1'b1;
            end else if (pt_clr[i]) begin
                st_d.ff[i] = 1'b0;
            end else if (pt_clk[i] && !st_q.clk_prev[i]) begin
                st_d.ff[i] = pt_d[i];
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign cell_q   = st_q.ff;
    assign cell_out = (cfg_comb & pt_d) | (~cfg_comb & st_q.ff);

endmodule : pmio_output_cell

// ===== hw/pmio_input_cell.sv
/*
 * Group of input macrocells: latch, register or pass per bit.
 * Assumes pin levels are synchronous to core_clk.
 */
`timescale 1ns/10ps
module pmio_input_cell
    import pmio_pkg::*;
#(
    parameter int W  = 8,
    parameter int NG = (W + GRP_W - 1) / GRP_W
) (
    input  wire logic                      core_clk,
    input  wire logic                      resetn,
    input  wire logic [W-1:0]              pin,
    input  wire logic [NG-1:0]             pt_ctl,
    input  wire logic                      ale,
    input  wire logic [NG-1:0]             cfg_ale_sel,
    input  wire pmio_imc_mode_type [W-1:0] cfg_mode,
    output logic      [W-1:0]              cell_q
);
    typedef struct packed {
        logic [W-1:0]  q;
        logic [NG-1:0] en_prev;
    } pmio_ic_state_type;

    pmio_ic_state_type st_q, st_d;
    logic [NG-1:0] en;

    always_comb begin
        st_d = st_q;
        for (int g = 0; g < NG; g++) begin
            en[g] = cfg_ale_sel[g] ? ale : pt_ctl[g];
        end
        st_d.en_prev = en;
        for (int i = 0; i < W; i++) begin
            unique case (cfg_mode[i])
                IMC_PASS: begin
                    st_d.q[i] = pin[i];
                end
                IMC_LATCH: begin
                    if (en[i / GRP_W]) begin
                        st_d.q[i] = pin[i];
                    end
                end
                IMC_REG: begin
                    if (en[i / GRP_W] && !st_q.en_prev[i / GRP_W]) begin
                        st_d.q[i] = pin[i];
                    end
                end
                default: begin
                    st_d.q[i] = pin[i];
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign cell_q = st_q.q;

endmodule : pmio_input_cell

// ===== hw/pmio_port.sv
/*
 * Macrocell and I/O port block: output and input macrocells,
 * port registers, pin output mux, driver enables and readback.
 * Assumes a synchronous MCU bus with active-low strobes, one
 * access per strobe; cfg_* inputs are static configuration.
 */
`timescale 1ns/10ps
module pmio_port
    import pmio_pkg::*;
(
    input  wire logic                      core_clk,
    input  wire logic                      resetn,
    input  wire logic [15:0]               bus_addr,
    input  wire logic [7:0]                bus_wdata,
    input  wire logic                      bus_wr_n,
    input  wire logic                      bus_rd_n,
    input  wire logic                      io_register_space_select,
    output logic      [7:0]                bus_rdata,
    input  wire logic                      mcu_ale,
    input  wire logic [7:0]                pin_a_in,
    input  wire logic [7:0]                pin_b_in,
    input  wire logic [7:0]                pin_c_in,
    input  wire logic [2:0]                pin_d_in,
    output logic      [7:0]                pin_a_out,
    output logic      [7:0]                pin_b_out,
    output logic      [7:0]                pin_c_out,
    output logic      [2:0]                pin_d_out,
    output logic      [7:0]                pin_a_oe,
    output logic      [7:0]                pin_b_oe,
    output logic      [7:0]                pin_c_oe,
    output logic      [2:0]                pin_d_oe,
    input  wire logic [7:0]                pt_oe_a,
    input  wire logic [7:0]                pt_oe_b,
    input  wire logic [7:0]                pt_oe_c,
    input  wire logic [2:0]                pt_oe_d,
    input  wire logic [7:0]                ab_pt_d,
    input  wire logic [7:0]                ab_pt_clk,
    input  wire logic [7:0]                ab_pt_pre,
    input  wire logic [7:0]                ab_pt_clr,
    input  wire logic [7:0]                bc_pt_d,
    input  wire logic [7:0]                bc_pt_clk,
    input  wire logic [7:0]                bc_pt_pre,
    input  wire logic [7:0]                bc_pt_clr,
    input  wire logic [1:0]                pt_imc_a,
    input  wire logic [1:0]                pt_imc_b,
    input  wire logic                      pt_imc_c,
    input  wire logic [1:0]                external_chip_selects,
    input  wire logic                      cfg_edge_load,
    input  wire logic [7:0]                cfg_ab_comb,
    input  wire logic [7:0]                cfg_bc_comb,
    input  wire logic [7:0]                cfg_a_from_ab,
    input  wire logic [7:0]                cfg_b_from_ab,
    input  wire logic [7:0]                cfg_b_from_bc,
    input  wire logic [7:0]                cfg_c_from_bc,
    input  wire logic [1:0]                cfg_d_ecs,
    input  wire logic [7:0]                cfg_oe_def_a,
    input  wire logic [7:0]                cfg_oe_def_b,
    input  wire logic [7:0]                cfg_oe_def_c,
    input  wire logic [2:0]                cfg_oe_def_d,
    input  wire pmio_imc_mode_type [7:0]   cfg_imc_mode_a,
    input  wire pmio_imc_mode_type [7:0]   cfg_imc_mode_b,
    input  wire pmio_imc_mode_type [3:0]   cfg_imc_mode_c,
    input  wire logic [1:0]                cfg_imc_ale_a,
    input  wire logic [1:0]                cfg_imc_ale_b,
    input  wire logic                      cfg_imc_ale_c,
    output logic      [7:0]                ab_group_macrocell,
    output logic      [7:0]                bc_group_macrocell,
    output logic      [7:0]                input_logic_cell_a,
    output logic      [7:0]                input_logic_cell_b,
    output logic      [3:0]                input_logic_cell_c
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [3:0][7:0] dout;
        logic [3:0][7:0] dir;
        logic [1:0][7:0] ctl;
        logic [7:0]      mask_ab;
        logic [7:0]      mask_bc;
        logic            wr_prev;
        logic [7:0]      wr_ofs;
        logic [7:0]      wr_data;
        logic [7:0]      lat_addr;
        logic [3:0][7:0] pin_o;
        logic [3:0][7:0] pin_oe;
        logic [7:0]      rdata;
        logic [7:0]      ab_fb;
        logic [7:0]      bc_fb;
    } pmio_state_type;

    pmio_state_type st_q, st_d;

    logic       wr_act;
    logic       rd_act;
    logic [7:0] ofs;
    logic       ld_strobe;
    logic [7:0] ld_ofs;
    logic [7:0] ld_data;
    logic [7:0] ab_ld;
    logic [7:0] bc_ld;
    logic [7:0] ab_q;
    logic [7:0] bc_q;
    logic [7:0] ab_out;
    logic [7:0] bc_out;
    logic [3:0][7:0] pin_in;
    logic [3:0][7:0] pt_oe;
    logic [3:0][7:0] oe_def;
    logic [3:0][7:0] mc_sel;
    logic [3:0][7:0] mc_val;
    logic [7:0]      c_cells;

    assign wr_act = io_register_space_select && !bus_wr_n;
    assign rd_act = io_register_space_select && !bus_rd_n;
    assign ofs    = bus_addr[7:0];

    // ****************************************
    // Macrocell load strobe
    // ****************************************
    // Edge mode loads what was on the bus during the strobe, at its
    // trailing edge; level mode loads every cycle the strobe is low.
    always_comb begin
        if (cfg_edge_load) begin
            ld_strobe = st_q.wr_prev && !wr_act;
            ld_ofs    = st_q.wr_ofs;
            ld_data   = st_q.wr_data;
        end else begin
            ld_strobe = wr_act;
            ld_ofs    = ofs;
            ld_data   = bus_wdata;
        end
        // A set mask bit leaves that flip-flop untouched
        ab_ld = (ld_strobe && ld_ofs == OFS_MC_AB) ? ~st_q.mask_ab : 8'h00;
        bc_ld = (ld_strobe && ld_ofs == OFS_MC_BC) ? ~st_q.mask_bc : 8'h00;
    end

    pmio_output_cell #(
        .W         (PORT_W)
    ) u_ab_cells (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .load_en   (ab_ld),
        .load_data (ld_data),
        .pt_d      (ab_pt_d),
        .pt_clk    (ab_pt_clk),
        .pt_pre    (ab_pt_pre),
        .pt_clr    (ab_pt_clr),
        .cfg_comb  (cfg_ab_comb),
        .cell_q    (ab_q),
        .cell_out  (ab_out)
    );

    pmio_output_cell #(
        .W         (PORT_W)
    ) u_bc_cells (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .load_en   (bc_ld),
        .load_data (ld_data),
        .pt_d      (bc_pt_d),
        .pt_clk    (bc_pt_clk),
        .pt_pre    (bc_pt_pre),
        .pt_clr    (bc_pt_clr),
        .cfg_comb  (cfg_bc_comb),
        .cell_q    (bc_q),
        .cell_out  (bc_out)
    );

    // ****************************************
    // Input macrocells
    // ****************************************
    pmio_input_cell #(
        .W           (PORT_W)
    ) u_imc_a (
        .core_clk    (core_clk),
        .resetn      (resetn),
        .pin         (pin_a_in),
        .pt_ctl      (pt_imc_a),
        .ale         (mcu_ale),
        .cfg_ale_sel (cfg_imc_ale_a),
        .cfg_mode    (cfg_imc_mode_a),
        .cell_q      (input_logic_cell_a)
    );

    pmio_input_cell #(
        .W           (PORT_W)
    ) u_imc_b (
        .core_clk    (core_clk),
        .resetn      (resetn),
        .pin         (pin_b_in),
        .pt_ctl      (pt_imc_b),
        .ale         (mcu_ale),
        .cfg_ale_sel (cfg_imc_ale_b),
        .cfg_mode    (cfg_imc_mode_b),
        .cell_q      (input_logic_cell_b)
    );

    pmio_input_cell #(
        .W           (GRP_W)
    ) u_imc_c (
        .core_clk    (core_clk),
        .resetn      (resetn),
        .pin         ({pin_c_in[7], pin_c_in[4], pin_c_in[3], pin_c_in[2]}),
        .pt_ctl      (pt_imc_c),
        .ale         (mcu_ale),
        .cfg_ale_sel (cfg_imc_ale_c),
        .cfg_mode    (cfg_imc_mode_c),
        .cell_q      (input_logic_cell_c)
    );

    // Port C cells mapped back onto their pin positions for readback
    assign c_cells = {input_logic_cell_c[3], 2'b00, input_logic_cell_c[2],
                      input_logic_cell_c[1], input_logic_cell_c[0], 2'b00};

    // ****************************************
    // Per-port views of pins and configuration
    // ****************************************
    assign pin_in = {5'h00, pin_d_in, pin_c_in, pin_b_in, pin_a_in};
    assign pt_oe  = {5'h00, pt_oe_d, pt_oe_c, pt_oe_b, pt_oe_a};
    assign oe_def = {5'h00, cfg_oe_def_d, cfg_oe_def_c, cfg_oe_def_b, cfg_oe_def_a};
    // A clear select bit makes the cell an internal node; pin stays free
    assign mc_sel = {5'h00, cfg_d_ecs, 1'b0,
                     cfg_c_from_bc & PC_CELL_PINS,
                     cfg_b_from_ab | cfg_b_from_bc,
                     cfg_a_from_ab};
    assign mc_val = {5'h00, external_chip_selects, 1'b0,
                     bc_out,
                     (cfg_b_from_ab & ab_out) | (~cfg_b_from_ab & bc_out),
                     ab_out};

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_d         = st_q;
        st_d.wr_prev = wr_act;
        st_d.ab_fb   = ab_out;
        st_d.bc_fb   = bc_out;
        if (wr_act) begin
            st_d.wr_ofs  = ofs;
            st_d.wr_data = bus_wdata;
        end
        if (mcu_ale) begin
            st_d.lat_addr = bus_addr[7:0];
        end

        // Run-time registers; configuration-time modes are cfg_* inputs
        if (wr_act) begin
            for (int p = 0; p < 4; p++) begin
                if (ofs == OFS_DOUT + 8'(p)) begin
                    st_d.dout[p] = bus_wdata;
                end
                if (ofs == OFS_DIR + 8'(p)) begin
                    st_d.dir[p] = bus_wdata;
                end
            end
            // Only ports A and B carry a control register
            if (ofs == OFS_CTL_A) begin
                st_d.ctl[0] = bus_wdata;
            end
            if (ofs == OFS_CTL_B) begin
                st_d.ctl[1] = bus_wdata;
            end
            if (ofs == OFS_MASK_AB) begin
                st_d.mask_ab = bus_wdata;
            end
            if (ofs == OFS_MASK_BC) begin
                st_d.mask_bc = bus_wdata;
            end
        end
        // Port D upper bits do not exist
        st_d.dout[3][7:PORT_D_W] = '0;
        st_d.dir[3][7:PORT_D_W]  = '0;

        // Pin drive: macrocell or chip select, then address, then data
        for (int p = 0; p < 4; p++) begin
            for (int b = 0; b < PORT_W; b++) begin
                if (mc_sel[p][b]) begin
                    st_d.pin_o[p][b] = mc_val[p][b];
                end else if (p < 2 && st_q.ctl[p[0]][b]) begin
                    st_d.pin_o[p][b] = st_q.lat_addr[b];
                end else begin
                    st_d.pin_o[p][b] = st_q.dout[p][b];
                end
                if (oe_def[p][b]) begin
                    st_d.pin_oe[p][b] = pt_oe[p][b] | st_q.dir[p][b];
                end else if (mc_sel[p][b]) begin
                    st_d.pin_oe[p][b] = 1'b1;
                end else begin
                    st_d.pin_oe[p][b] = st_q.dir[p][b];
                end
            end
        end

        // Readback: one source per access, unmapped reads zero
        st_d.rdata = 8'h00;
        if (rd_act) begin
            for (int p = 0; p < 4; p++) begin
                if (ofs == OFS_DIN + 8'(p)) begin
                    st_d.rdata = pin_in[p];
                end
                if (ofs == OFS_DOUT + 8'(p)) begin
                    st_d.rdata = st_q.dout[p];
                end
                if (ofs == OFS_DIR + 8'(p)) begin
                    st_d.rdata = st_q.dir[p];
                end
            end
            unique case (ofs)
                OFS_CTL_A: begin
                    st_d.rdata = st_q.ctl[0];
                end
                OFS_CTL_B: begin
                    st_d.rdata = st_q.ctl[1];
                end
                OFS_MC_AB: begin
                    st_d.rdata = ab_q;
                end
                OFS_MC_BC: begin
                    st_d.rdata = bc_q;
                end
                OFS_MASK_AB: begin
                    st_d.rdata = st_q.mask_ab;
                end
                OFS_MASK_BC: begin
                    st_d.rdata = st_q.mask_bc;
                end
                OFS_IMC_A: begin
                    st_d.rdata = input_logic_cell_a;
                end
                OFS_IMC_B: begin
                    st_d.rdata = input_logic_cell_b;
                end
                OFS_IMC_C: begin
                    st_d.rdata = c_cells;
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_q         <= '0;
            st_q.dout    <= {4{RST_DOUT}};
            st_q.dir     <= {4{RST_DIR}};
            st_q.ctl     <= {2{RST_CTL}};
            st_q.mask_ab <= RST_MASK;
            st_q.mask_bc <= RST_MASK;
        end else begin
            st_q <= st_d;
        end
    end

    assign bus_rdata          = st_q.rdata;
    assign pin_a_out          = st_q.pin_o[0];
    assign pin_b_out          = st_q.pin_o[1];
    assign pin_c_out          = st_q.pin_o[2];
    assign pin_d_out          = st_q.pin_o[3][PORT_D_W-1:0];
    assign pin_a_oe           = st_q.pin_oe[0];
    assign pin_b_oe           = st_q.pin_oe[1];
    assign pin_c_oe           = st_q.pin_oe[2];
    assign pin_d_oe           = st_q.pin_oe[3][PORT_D_W-1:0];
    assign ab_group_macrocell = st_q.ab_fb;
    assign bc_group_macrocell = st_q.bc_fb;

endmodule : pmio_port

// ===== testbench/pmio_port_properties.sv
/* Checker for the read path, pin drivers and macrocell feedback of pmio_port.
   Assumes the cfg inputs stay static while the block is out of reset. */
`timescale 1ns/10ps
module pmio_port_properties
    import pmio_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic [15:0] bus_addr,
    input wire logic        bus_wr_n,
    input wire logic        bus_rd_n,
    input wire logic        io_register_space_select,
    input wire logic [7:0]  bus_rdata,
    input wire logic [2:0]  pt_oe_d,
    input wire logic [2:0]  cfg_oe_def_d,
    input wire logic [2:0]  pin_d_oe,
    input wire logic [2:0]  pin_d_out,
    input wire logic [1:0]  cfg_d_ecs,
    input wire logic [1:0]  external_chip_selects,
    input wire logic [7:0]  cfg_b_from_ab,
    input wire logic [7:0]  cfg_oe_def_b,
    input wire logic [7:0]  pin_b_oe,
    input wire logic [7:0]  cfg_ab_comb,
    input wire logic [7:0]  ab_pt_d,
    input wire logic [7:0]  ab_group_macrocell
);
    // ****************************************
    // Properties
    // ****************************************
    wire       rd    = io_register_space_select && !bus_rd_n;
    wire       wr    = io_register_space_select && !bus_wr_n;
    wire [2:0] pt_on = pt_oe_d & cfg_oe_def_d;
    wire [7:0] lo_b  = cfg_b_from_ab & ~cfg_oe_def_b;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence s_rd_d; rd && bus_addr[7:0] == 8'h03; endsequence
    sequence s_rd_gap; rd && bus_addr[7:0] > OFS_IMC_C; endsequence
    property p_idle; !rd |=> bus_rdata == 8'h00; endproperty
    property p_wr; wr && !rd |=> bus_rdata == 8'h00; endproperty
    property p_rd_d; s_rd_d |=> bus_rdata[7:3] == 5'h00; endproperty
    property p_gap; s_rd_gap |=> bus_rdata == 8'h00; endproperty
    property p_oe_pt; pt_on != 3'h0 |=> (pin_d_oe & $past(pt_on)) == $past(pt_on); endproperty
    property p_ecs; cfg_d_ecs[0] |=> pin_d_out[1] == $past(external_chip_selects[0]); endproperty
    property p_oe_lo; lo_b != 8'h00 |=> (pin_b_oe & $past(lo_b)) == $past(lo_b); endproperty
    property p_comb; cfg_ab_comb[7] |=> ab_group_macrocell[7] == $past(ab_pt_d[7]); endproperty
    a_idle: assert property (p_idle) else $error("read data not cleared");
    a_wr: assert property (p_wr) else $error("read data during write");
    a_rd_d: assert property (p_rd_d) else $error("port d upper bits set");
    a_gap: assert property (p_gap) else $error("unmapped read not zero");
    a_oe_pt: assert property (p_oe_pt) else $error("oe term ignored");
    a_ecs: assert property (p_ecs) else $error("chip select not on pin");
    a_oe_lo: assert property (p_oe_lo) else $error("logic output not driven");
    a_comb: assert property (p_comb) else $error("node feedback wrong");
endmodule : pmio_port_properties
bind pmio_port pmio_port_properties pmio_port_properties_inst (.*);

// ===== testbench/pmio_mcu_model.sv
/* Behavioural MCU bus master driving the register strobes of pmio_port.
   Assumes the bench issues one access at a time. */
`timescale 1ns/10ps
module pmio_mcu_model
    import pmio_pkg::*;
(
    input  wire logic [7:0]  bus_rdata,
    input  wire logic        core_clk,
    output logic      [15:0] bus_addr,
    output logic      [7:0]  bus_wdata,
    output logic             bus_wr_n,
    output logic             bus_rd_n,
    output logic             io_register_space_select,
    output logic             mcu_ale
);
    initial begin
        bus_addr = 16'h0000;
        bus_wdata = 8'h00;
        {io_register_space_select, mcu_ale, bus_wr_n, bus_rd_n} = 4'h3;
    end
    // ****************************************
    // One access, strobes held across one rising edge
    // ****************************************
    task automatic access(input logic w, input logic [7:0] ofs, input logic [7:0] wd,
                          output logic [7:0] rdv);
        @(negedge core_clk);
        bus_addr = {8'h00, ofs};
        bus_wdata = wd;
        {io_register_space_select, mcu_ale, bus_wr_n, bus_rd_n} = {2'b11, !w, w};
        @(negedge core_clk);
        {io_register_space_select, mcu_ale, bus_wr_n, bus_rd_n} = 4'h3;
        // Released lines flip so a stale value never passes for a held one
        bus_addr = ~bus_addr;
        bus_wdata = ~bus_wdata;
        rdv = bus_rdata;
    endtask : access
endmodule : pmio_mcu_model

// ===== testbench/testbench.sv
/* Self-checking bench for pmio_port: bus tasks through the MCU model.
   Assumes the checker is bound; cfg inputs stay static except cfg_edge_load, set near the end. */
`timescale 1ns/10ps
module testbench
    import pmio_pkg::*;
;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [15:0] bus_addr;
    logic [7:0] bus_wdata, bus_rdata, rd_val, ab_pt_clk, ab_pt_pre, ab_pt_clr;
    logic bus_wr_n, bus_rd_n, io_register_space_select, mcu_ale, pt_imc_c, cfg_edge_load;
    logic cfg_imc_ale_c;
    logic [7:0] pin_a_in, pin_b_in, pin_c_in, pin_a_out, pin_b_out, pin_c_out;
    logic [7:0] pin_a_oe, pin_b_oe, pin_c_oe, pt_oe_a, pt_oe_b, pt_oe_c;
    logic [2:0] pin_d_in, pin_d_out, pin_d_oe, pt_oe_d, cfg_oe_def_d;
    logic [7:0] bc_pt_d, bc_pt_clk, bc_pt_pre, bc_pt_clr, cfg_ab_comb, cfg_bc_comb;
    logic [7:0] ab_pt_d = 8'h00;
    logic [1:0] pt_imc_a, pt_imc_b, external_chip_selects, cfg_d_ecs, cfg_imc_ale_a;
    logic [1:0] cfg_imc_ale_b;
    logic [7:0] cfg_a_from_ab, cfg_b_from_ab, cfg_b_from_bc, cfg_c_from_bc;
    logic [7:0] cfg_oe_def_a, cfg_oe_def_b, cfg_oe_def_c, ab_group_macrocell;
    logic [7:0] bc_group_macrocell, input_logic_cell_a, input_logic_cell_b;
    logic [3:0] input_logic_cell_c;
    pmio_imc_mode_type [7:0] cfg_imc_mode_a, cfg_imc_mode_b;
    pmio_imc_mode_type [3:0] cfg_imc_mode_c;
    int mismatches = 0;
    int check_count = 0;
    pmio_port pmio_port_inst (.*);
    pmio_mcu_model pmio_mcu_model_inst (.*);
    always #4 core_clk = ~core_clk;
    // Toggling term keeps the combinational node visibly alive
    always @(negedge core_clk) ab_pt_d <= {~ab_pt_d[7], 7'h00};
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        pmio_mcu_model_inst.access(1'b1, ofs, d, rd_val);
        repeat (2) @(negedge core_clk);
    endtask : wr
    task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
        pmio_mcu_model_inst.access(1'b0, ofs, 8'h00, rd_val);
        chk(rd_val, exp);
    endtask : rd
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #20000;
        mismatches++;
        end_of_test();
    end
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        {pin_c_in, pt_oe_a, pt_oe_b, ab_pt_clk, ab_pt_pre, ab_pt_clr, bc_pt_d} = '0;
        {bc_pt_clk, bc_pt_pre, bc_pt_clr, pt_imc_a, pt_imc_b, pt_imc_c, cfg_edge_load} = '0;
        {cfg_bc_comb, cfg_a_from_ab, cfg_b_from_bc, cfg_c_from_bc, cfg_oe_def_a} = '0;
        {cfg_oe_def_b, cfg_imc_ale_a, cfg_imc_ale_c} = '0;
        {pin_a_in, pin_b_in, pin_d_in, pt_oe_c, cfg_oe_def_c} = {16'h965a, 3'h5, 16'h050f};
        {pt_oe_d, cfg_oe_def_d, external_chip_selects, cfg_d_ecs} = {3'h1, 3'h1, 4'hb};
        {cfg_ab_comb, cfg_b_from_ab, cfg_imc_ale_b} = {8'h80, 8'h01, 2'b11};
        cfg_imc_mode_a = '{default: IMC_PASS};
        cfg_imc_mode_b = '{default: IMC_REG};
        cfg_imc_mode_c = '{default: IMC_LATCH};
        repeat (4) @(negedge core_clk);
        resetn = 1'b1;
        rd(OFS_MASK_AB, RST_MASK);
        rd(OFS_MASK_BC, RST_MASK);
        rd(OFS_DIR, RST_DIR);
        rd(OFS_CTL_A, RST_CTL);
        chk(pin_b_oe, 8'h01);
        chk(pin_c_oe, 8'h05);
        chk({5'h00, pin_d_out}, 8'h04);
        rd(OFS_DIN + 8'h03, 8'h05);
        chk(input_logic_cell_b, 8'h5a);
        pin_b_in = 8'hc3;
        repeat (3) @(negedge core_clk);
        chk(input_logic_cell_b, 8'h5a);
        rd(OFS_IMC_A, 8'h96);
        chk(input_logic_cell_b, 8'hc3);
        chk(input_logic_cell_a, 8'h96);
        wr(OFS_MASK_AB, 8'h0f);
        wr(OFS_MC_AB, 8'ha5);
        rd(OFS_MC_AB, 8'ha0);
        chk(ab_group_macrocell & 8'h7f, 8'h20);
        wr(OFS_DIR, 8'hff);
        wr(OFS_DOUT, 8'h3c);
        chk(pin_a_out, 8'h3c);
        chk(pin_a_oe, 8'hff);
        wr(OFS_CTL_A, 8'hff);
        chk(pin_a_out, OFS_CTL_A);
        wr(OFS_CTL_A, 8'h00);
        chk(pin_a_out, 8'h3c);
        wr(8'h15, 8'hff);
        rd(8'h15, 8'h00);
        {pin_c_in, pt_imc_c, cfg_edge_load} = {8'h9c, 2'b11};
        rd(OFS_IMC_C, 8'h9c);
        wr(OFS_MC_AB, 8'h5a);
        rd(OFS_MC_AB, 8'h50);
        end_of_test();
    end
endmodule : testbench
